/* File: hw/fcs_host.v */
// Notes on behaviour
// - auto-select is three writes, then the host issues a read.
// - reset aborts auto-select entry; host writes reset to leave auto-select.
// - program is two unlocks, set-up, then address and data.
// - chip erase is two unlocks, set-up, two unlocks, chip erase code.
// - sector erase is six writes, last holds sector address and code.
// - each further sector write must follow within 50 us.
// - unlock addresses 555H/2AAH word or AAAH/555H byte, data AAH, 55H.
// - command codes F0, A0, 80, 10, 30, B0, 90 as write cycles.
//
// The address map and the APB slave port are this design's own decisions.
`include "fcs_map.vh"

module fcs_host #(
    parameter AW      = 21,
    parameter DW      = 16,
    parameter WIN_CYC = `FCS_WIN_CYC
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    output wire [AW-1:0] flash_addr,
    input  wire [DW-1:0] flash_dq_in,
    output wire [DW-1:0] flash_dq_out,
    output wire          flash_dq_oe,
    output wire          flash_ce_n,
    output wire          flash_we_n,
    output wire          flash_oe_n,
    output reg           flash_reset_n_q,
    output reg           flash_byte_n_q,
    input  wire          done_flag_pin
);
    localparam S_IDLE  = 3'd0;
    localparam S_ISSUE = 3'd1;
    localparam S_WAIT  = 3'd2;
    localparam S_HWRST = 3'd3;
    localparam S_SUSPW = 3'd4;
    localparam S_POLL  = 3'd5;

    localparam [31:0] WIN_W  = WIN_CYC;
    localparam [31:0] SUSP_W = `FCS_SUSP_CYC;
    localparam [31:0] RP_W   = `FCS_RP_CYC;
    localparam [13:0] WIN_N  = WIN_W[13:0];
    localparam [13:0] SUSP_N = SUSP_W[13:0];
    localparam [13:0] RP_N   = RP_W[13:0];

    reg  [2:0]    st_q;
    reg  [3:0]    op_q;
    reg  [2:0]    step_q;
    reg  [AW-1:0] addr_q;
    reg  [DW-1:0] wdata_q;
    reg  [DW-1:0] rdata_q;
    reg  [13:0]   wait_q;
    reg  [13:0]   win_q;
    reg           pfail_q;
    reg           badop_q;
    reg           first_q;
    reg           retry_q;
    reg           start_q;

    wire          cyc_done;
    wire [DW-1:0] cyc_rdata;
    wire [DW-1:0] dq_sync;
    wire          ready_sync;

    fcs_sync #(.W(DW + 1)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({done_flag_pin, flash_dq_in}),
        .q       ({ready_sync, dq_sync})
    );

    // one step of the current sequence: {write, address, data}
    reg  [2:0]    nstep;
    reg           s_wr;
    reg  [AW-1:0] s_addr;
    reg  [DW-1:0] s_data;
    reg  [AW-1:0] ua1;
    reg  [AW-1:0] ua2;

    always @* begin
        ua1    = flash_byte_n_q ? `FCS_UA1_WORD : `FCS_UA1_BYTE;
        ua2    = flash_byte_n_q ? `FCS_UA2_WORD : `FCS_UA2_BYTE;
        nstep  = 3'd1;
        s_wr   = 1'b1;
        s_addr = addr_q;
        s_data = `FCS_CMD_RESET;
        // unlock pair opens every multi-cycle sequence
        if (step_q == 3'd0 || step_q == 3'd3) begin
            s_addr = ua1;
            s_data = `FCS_CMD_UNLOCK1;
        end else if (step_q == 3'd1 || step_q == 3'd4) begin
            s_addr = ua2;
            s_data = `FCS_CMD_UNLOCK2;
        end
        case (op_q)
            `FCS_OP_READ, `FCS_OP_POLL: begin
                s_wr   = 1'b0;
                s_addr = addr_q;
            end
            `FCS_OP_RESET: begin
                s_addr = {AW{1'b0}};
                s_data = `FCS_CMD_RESET;
            end
            `FCS_OP_PROGRAM: begin
                nstep = 3'd4;
                if (step_q == 3'd2) begin
                    s_addr = ua1;
                    s_data = `FCS_CMD_PROG;
                end else if (step_q == 3'd3) begin
                    s_addr = addr_q;
                    s_data = wdata_q;
                end
            end
            `FCS_OP_CHIP_ERASE, `FCS_OP_SECT_ERASE: begin
                nstep = 3'd6;
                if (step_q == 3'd2) begin
                    s_addr = ua1;
                    s_data = `FCS_CMD_ERASE;
                end else if (step_q == 3'd5) begin
                    s_addr = (op_q == `FCS_OP_CHIP_ERASE) ? ua1 : addr_q;
                    s_data = (op_q == `FCS_OP_CHIP_ERASE) ? `FCS_CMD_CHIP
                                                          : `FCS_CMD_SECT;
                end
            end
            `FCS_OP_ADD_SECT: begin
                s_addr = addr_q;
                s_data = `FCS_CMD_SECT;
            end
            `FCS_OP_SUSPEND: begin
                s_addr = {AW{1'b0}};
                s_data = `FCS_CMD_SUSPEND;
            end
            `FCS_OP_RESUME: begin
                s_addr = {AW{1'b0}};
                s_data = `FCS_CMD_SECT;
            end
            `FCS_OP_AUTOSEL: begin
                nstep = 3'd3;
                if (step_q == 3'd2) begin
                    s_addr = ua1;
                    s_data = `FCS_CMD_AUTOSEL;
                end
            end
            default: begin
                nstep = 3'd1;
            end
        endcase
    end

    fcs_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (start_q),
        .is_write   (s_wr),
        .addr       (s_addr),
        .wdata      (s_data),
        .dq_sync    (dq_sync),
        .f_addr_q   (flash_addr),
        .f_dq_out_q (flash_dq_out),
        .f_dq_oe_q  (flash_dq_oe),
        .f_ce_n_q   (flash_ce_n),
        .f_we_n_q   (flash_we_n),
        .f_oe_n_q   (flash_oe_n),
        .rdata_q    (cyc_rdata),
        .done_q     (cyc_done)
    );

    // apb slave: zero wait states, unmapped offsets error
    wire acc    = psel && penable;
    wire wr_acc = acc && pwrite;
    wire mapped = (paddr == `FCS_REG_CTRL)  || (paddr == `FCS_REG_ADDR) ||
                  (paddr == `FCS_REG_WDATA) || (paddr == `FCS_REG_STAT) ||
                  (paddr == `FCS_REG_RDATA);
    wire busy   = (st_q != S_IDLE);
    wire go     = wr_acc && (paddr == `FCS_REG_CTRL) && !busy;
    wire [3:0] go_op = pwdata[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always @* begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `FCS_REG_CTRL: begin
                    prdata[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB] = op_q;
                    prdata[`FCS_CTRL_BYTE] = ~flash_byte_n_q;
                end
                `FCS_REG_ADDR:  prdata[AW-1:0] = addr_q;
                `FCS_REG_WDATA: prdata[DW-1:0] = wdata_q;
                `FCS_REG_STAT: begin
                    prdata[`FCS_STAT_BUSY]   = busy;
                    prdata[`FCS_STAT_READY]  = ready_sync;
                    prdata[`FCS_STAT_WINDOW] = (win_q != 14'h0000);
                    prdata[`FCS_STAT_PFAIL]  = pfail_q;
                    prdata[`FCS_STAT_BADOP]  = badop_q;
                end
                `FCS_REG_RDATA: prdata[DW-1:0] = rdata_q;
                default:        prdata = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q            <= S_IDLE;
            op_q            <= `FCS_OP_READ;
            step_q          <= 3'd0;
            addr_q          <= {AW{1'b0}};
            wdata_q         <= {DW{1'b0}};
            rdata_q         <= {DW{1'b0}};
            wait_q          <= 14'h0000;
            win_q           <= 14'h0000;
            pfail_q         <= 1'b0;
            badop_q         <= 1'b0;
            first_q         <= 1'b0;
            retry_q         <= 1'b0;
            start_q         <= 1'b0;
            flash_reset_n_q <= 1'b1;
            flash_byte_n_q  <= 1'b1;
        end else begin
            start_q <= 1'b0;
            // gap to the next sector must stay under the window
            if (win_q != 14'h0000) begin
                win_q <= win_q - 14'h0001;
            end
            if (wr_acc && paddr == `FCS_REG_ADDR && !busy) begin
                addr_q <= pwdata[AW-1:0];
            end
            if (wr_acc && paddr == `FCS_REG_WDATA && !busy) begin
                wdata_q <= pwdata[DW-1:0];
            end
            case (st_q)
                S_IDLE: begin
                    if (go) begin
                        op_q           <= go_op;
                        step_q         <= 3'd0;
                        first_q        <= 1'b1;
                        retry_q        <= 1'b0;
                        pfail_q        <= 1'b0;
                        badop_q        <= 1'b0;
                        flash_byte_n_q <= ~pwdata[`FCS_CTRL_BYTE];
                        if (go_op == `FCS_OP_HW_RESET) begin
                            st_q            <= S_HWRST;
                            wait_q          <= RP_N;
                            flash_reset_n_q <= 1'b0;
                        end else if (go_op > `FCS_OP_HW_RESET) begin
                            badop_q <= 1'b1;
                        end else begin
                            st_q    <= S_ISSUE;
                            start_q <= 1'b1;
                        end
                    end
                end
                S_ISSUE: begin
                    st_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        // polling keeps the previous read for the comparison
                        if (op_q != `FCS_OP_POLL) begin
                            rdata_q <= cyc_rdata;
                        end
                        if (step_q + 3'd1 < nstep) begin
                            step_q  <= step_q + 3'd1;
                            start_q <= 1'b1;
                            st_q    <= S_ISSUE;
                        end else if (op_q == `FCS_OP_SECT_ERASE ||
                                     op_q == `FCS_OP_ADD_SECT) begin
                            win_q <= WIN_N;
                            st_q  <= S_IDLE;
                        end else if (op_q == `FCS_OP_SUSPEND) begin
                            // a suspend inside the window acts at once
                            wait_q <= (win_q != 14'h0000) ? 14'h0001 : SUSP_N;
                            win_q  <= 14'h0000;
                            st_q   <= S_SUSPW;
                        end else if (op_q == `FCS_OP_POLL) begin
                            st_q <= S_POLL;
                        end else begin
                            if (op_q != `FCS_OP_READ) begin
                                win_q <= 14'h0000;
                            end
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_POLL: begin
                    // stable toggle bit on two reads means finished
                    rdata_q <= cyc_rdata;
                    if (first_q) begin
                        first_q <= 1'b0;
                        start_q <= 1'b1;
                        st_q    <= S_ISSUE;
                    end else if (rdata_q[`FCS_DQ_TOGGLE] == cyc_rdata[`FCS_DQ_TOGGLE]) begin
                        st_q <= S_IDLE;
                    end else if (retry_q) begin
                        pfail_q <= 1'b1;
                        st_q    <= S_IDLE;
                    end else if (cyc_rdata[`FCS_DQ_TIMEOUT]) begin
                        // the flag may rise just as the operation ends: read again
                        retry_q <= 1'b1;
                        start_q <= 1'b1;
                        st_q    <= S_ISSUE;
                    end else begin
                        start_q <= 1'b1;
                        st_q    <= S_ISSUE;
                    end
                end
                S_HWRST: begin
                    if (wait_q <= 14'h0001) begin
                        flash_reset_n_q <= 1'b1;
                        win_q           <= 14'h0000;
                        st_q            <= S_IDLE;
                    end else begin
                        wait_q <= wait_q - 14'h0001;
                    end
                end
                S_SUSPW: begin
                    if (wait_q <= 14'h0001) begin
                        st_q <= S_IDLE;
                    end else begin
                        wait_q <= wait_q - 14'h0001;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: hw/fcs_map.vh */
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

// register byte offsets
`define FCS_REG_CTRL      8'h00
`define FCS_REG_ADDR      8'h04
`define FCS_REG_WDATA     8'h08
`define FCS_REG_STAT      8'h0C
`define FCS_REG_RDATA     8'h10

// control register fields
`define FCS_CTRL_OP_LSB   0
`define FCS_CTRL_OP_MSB   3
`define FCS_CTRL_BYTE     8

// status register fields
`define FCS_STAT_BUSY     0
`define FCS_STAT_READY    1
`define FCS_STAT_WINDOW   2
`define FCS_STAT_PFAIL    3
`define FCS_STAT_BADOP    4

// operations
`define FCS_OP_READ       4'h0
`define FCS_OP_RESET      4'h1
`define FCS_OP_PROGRAM    4'h2
`define FCS_OP_CHIP_ERASE 4'h3
`define FCS_OP_SECT_ERASE 4'h4
`define FCS_OP_ADD_SECT   4'h5
`define FCS_OP_SUSPEND    4'h6
`define FCS_OP_RESUME     4'h7
`define FCS_OP_AUTOSEL    4'h8
`define FCS_OP_POLL       4'h9
`define FCS_OP_HW_RESET   4'hA

// command data codes
`define FCS_CMD_UNLOCK1   16'h00AA
`define FCS_CMD_UNLOCK2   16'h0055
`define FCS_CMD_RESET     16'h00F0
`define FCS_CMD_PROG      16'h00A0
`define FCS_CMD_ERASE     16'h0080
`define FCS_CMD_CHIP      16'h0010
`define FCS_CMD_SECT      16'h0030
`define FCS_CMD_SUSPEND   16'h00B0
`define FCS_CMD_AUTOSEL   16'h0090

// unlock addresses, word and byte mode
`define FCS_UA1_WORD      21'h000555
`define FCS_UA2_WORD      21'h0002AA
`define FCS_UA1_BYTE      21'h000AAA
`define FCS_UA2_BYTE      21'h000555

// status bit positions in read data
`define FCS_DQ_POLL       7
`define FCS_DQ_TOGGLE     6
`define FCS_DQ_TIMEOUT    5

// timing
`define FCS_CLK_MHZ       200
`define FCS_T_SETUP_NS    10
`define FCS_T_WP_NS       45
`define FCS_T_HOLD_NS     20
`define FCS_T_ACC_NS      70
`define FCS_T_RP_NS       500
`define FCS_T_WIN_US      50
`define FCS_T_SUSP_US     20
`define FCS_CYC_NS(t)     (((t) * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_SETUP_CYC     `FCS_CYC_NS(`FCS_T_SETUP_NS)
`define FCS_WP_CYC        `FCS_CYC_NS(`FCS_T_WP_NS)
`define FCS_HOLD_CYC      `FCS_CYC_NS(`FCS_T_HOLD_NS)
`define FCS_ACC_CYC       `FCS_CYC_NS(`FCS_T_ACC_NS)
`define FCS_RP_CYC        `FCS_CYC_NS(`FCS_T_RP_NS)
`define FCS_WIN_CYC       (`FCS_T_WIN_US * `FCS_CLK_MHZ)
`define FCS_SUSP_CYC      (`FCS_T_SUSP_US * `FCS_CLK_MHZ)

`endif

/* File: hw/fcs_sync.v */
module fcs_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d[i];
                    sync_q <= meta_q;
                end
            end
            assign q[i] = sync_q;
        end
    endgenerate
endmodule

/* File: hw/fcs_bus_cycle.v */
`include "fcs_map.vh"

// one flash bus cycle: setup, strobe, hold
module fcs_bus_cycle #(
    parameter AW = 21,
    parameter DW = 16
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          start,
    input  wire          is_write,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    input  wire [DW-1:0] dq_sync,
    output reg  [AW-1:0] f_addr_q,
    output reg  [DW-1:0] f_dq_out_q,
    output reg           f_dq_oe_q,
    output reg           f_ce_n_q,
    output reg           f_we_n_q,
    output reg           f_oe_n_q,
    output reg  [DW-1:0] rdata_q,
    output reg           done_q
);
    localparam C_IDLE   = 2'd0;
    localparam C_SETUP  = 2'd1;
    localparam C_STROBE = 2'd2;
    localparam C_HOLD   = 2'd3;
    // reads wait two extra cycles for the input synchroniser
    localparam [31:0] SETUP_W = `FCS_SETUP_CYC;
    localparam [31:0] WP_W    = `FCS_WP_CYC;
    localparam [31:0] RD_W    = `FCS_ACC_CYC + 2;
    localparam [31:0] HOLD_W  = `FCS_HOLD_CYC;
    localparam [7:0]  SETUP_N = SETUP_W[7:0];
    localparam [7:0]  WP_N    = WP_W[7:0];
    localparam [7:0]  RD_N    = RD_W[7:0];
    localparam [7:0]  HOLD_N  = HOLD_W[7:0];

    reg [1:0] st_q;
    reg [7:0] cnt_q;
    reg       wr_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= C_IDLE;
            cnt_q      <= 8'h00;
            wr_q       <= 1'b0;
            f_addr_q   <= {AW{1'b0}};
            f_dq_out_q <= {DW{1'b0}};
            f_dq_oe_q  <= 1'b0;
            f_ce_n_q   <= 1'b1;
            f_we_n_q   <= 1'b1;
            f_oe_n_q   <= 1'b1;
            rdata_q    <= {DW{1'b0}};
            done_q     <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                C_IDLE: begin
                    if (start) begin
                        st_q       <= C_SETUP;
                        cnt_q      <= SETUP_N;
                        wr_q       <= is_write;
                        f_addr_q   <= addr;
                        f_dq_out_q <= wdata;
                        f_dq_oe_q  <= is_write;
                        f_ce_n_q   <= 1'b0;
                    end
                end
                C_SETUP: begin
                    if (cnt_q <= 8'h01) begin
                        st_q     <= C_STROBE;
                        cnt_q    <= wr_q ? WP_N : RD_N;
                        f_we_n_q <= ~wr_q;
                        f_oe_n_q <= wr_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                C_STROBE: begin
                    if (cnt_q <= 8'h01) begin
                        // command latches on this rising we edge
                        st_q     <= C_HOLD;
                        cnt_q    <= HOLD_N;
                        f_we_n_q <= 1'b1;
                        f_oe_n_q <= 1'b1;
                        if (!wr_q) begin
                            rdata_q <= dq_sync;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                C_HOLD: begin
                    if (cnt_q <= 8'h01) begin
                        st_q      <= C_IDLE;
                        f_dq_oe_q <= 1'b0;
                        f_ce_n_q  <= 1'b1;
                        done_q    <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= C_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verification/fcs_host_sva.sv */
module fcs_host_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [20:0] flash_addr,
    input wire [15:0] flash_dq_out,
    input wire        flash_dq_oe,
    input wire        flash_ce_n,
    input wire        flash_we_n,
    input wire        flash_oe_n,
    input wire        flash_reset_n_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_sel; !flash_we_n || !flash_oe_n |-> !flash_ce_n; endproperty
    a_sel: assert property (p_sel) else $error("strobe outside select");
    property p_rd; !flash_oe_n |-> flash_we_n && !flash_dq_oe; endproperty
    a_rd: assert property (p_rd) else $error("read cycle drives bus");
    property p_hold; !flash_we_n |-> flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write cycle not held");
    property p_wp; $fell(flash_we_n) |-> ##8 !flash_we_n ##1 flash_we_n; endproperty
    a_wp: assert property (p_wp) else $error("write pulse length");
    property p_oe; $fell(flash_oe_n) |-> ##15 !flash_oe_n ##1 flash_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("read pulse length");
    property p_gap; $rose(flash_ce_n) |-> flash_ce_n [*2]; endproperty
    a_gap: assert property (p_gap) else $error("cycles too close");
    property p_rp; $fell(flash_reset_n_q) |-> ##99 !flash_reset_n_q ##1 flash_reset_n_q;
    endproperty
    a_rp: assert property (p_rp) else $error("reset pulse length");
    property p_rpq; !flash_ce_n |-> flash_reset_n_q; endproperty
    a_rpq: assert property (p_rpq) else $error("bus cycle in reset");
    property p_apb; psel && penable && paddr[1:0] == 2'b00 |-> pready && pslverr == (paddr > 8'h10);
    endproperty
    a_apb: assert property (p_apb) else $error("bus answer wrong");
endmodule

bind fcs_host fcs_host_sva u_fcs_host_sva (.*);

/* File: verification/fcs_flash_model.sv */
`include "fcs_map.vh"

module fcs_flash_model #(
    parameter logic [15:0] ID_CODE = 16'h00A5
) (
    input  wire logic [20:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_reset_n_q,
    input  wire logic        flash_byte_n_q,
    output      logic [15:0] flash_dq_in,
    output      logic        done_flag_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem[16];
    logic [15:0] q = 16'h0000;
    logic [15:0] d;
    logic [3:0]  sel = 4'h0;
    logic        busy = 0, ers = 0, chp = 0, susp = 0, asel = 0, win = 0, tg = 0, pb7 = 0;
    int          cyc = 0, left = 0;
    wire logic [20:0] ua1 = flash_byte_n_q ? `FCS_UA1_WORD : `FCS_UA1_BYTE;
    wire logic [20:0] ua2 = flash_byte_n_q ? `FCS_UA2_WORD : `FCS_UA2_BYTE;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    assign done_flag_pin = !busy;
    // released bus shows the inverse, so a stale value never passes
    assign flash_dq_in = flash_oe_n ? ~q : q;
    always @(negedge flash_reset_n_q) {busy, ers, chp, susp, asel, win, cyc} = 0;
    always #10 if ((busy || win) && --left == 0) begin
        if (win) begin
            {win, busy} = 2'b01;
            left = 300;
        end else begin
            if (ers) foreach (mem[i]) if (sel[i/4]) mem[i] = 16'hFFFF;
            {busy, ers, chp} = 3'b000;
        end
    end
    always @(posedge flash_we_n) if (!flash_ce_n) begin
        d = flash_dq_out;
        if (busy) begin
            if (d == `FCS_CMD_SUSPEND && ers && !chp) {busy, susp} = 2'b01;
        end else if (win) begin
            if (d == `FCS_CMD_SECT) sel[flash_addr[3:2]] = 1'b1;
            else if (d == `FCS_CMD_SUSPEND) {win, susp} = 2'b01;
            else {win, ers, sel} = 0;
        end else if (d == `FCS_CMD_RESET) {asel, cyc} = 0;
        else if (susp && cyc == 0 && d == `FCS_CMD_SECT) {busy, susp} = 2'b10;
        else case (cyc)
            0, 3: cyc = flash_addr == ua1 && d == `FCS_CMD_UNLOCK1 ? cyc + 1 : 0;
            1, 4: cyc = flash_addr == ua2 && d == `FCS_CMD_UNLOCK2 ? cyc + 1 : 0;
            2: begin
                asel = d == `FCS_CMD_AUTOSEL;
                cyc = d == `FCS_CMD_PROG ? 6 : d == `FCS_CMD_ERASE && !susp ? 3 : 0;
            end
            5: begin
                cyc = 0;
                chp = d == `FCS_CMD_CHIP;
                ers = chp || d == `FCS_CMD_SECT;
                sel = chp ? 4'hF : 4'h0;
                sel[flash_addr[3:2]] = ers;
                {win, busy} = {ers && !chp, chp};
                left = chp ? 300 : 100;
            end
            default: begin
                mem[flash_addr[3:0]] &= d;
                pb7 = d[7];
                {cyc, busy, ers, chp} = {32'd0, 3'b100};
                left = 50;
            end
        endcase
    end
    always @(negedge flash_oe_n) if (!flash_ce_n) begin
        if (asel) q = flash_addr[7:0] == 8'h02 ? 16'h0000 : ID_CODE;
        else if (busy) begin
            tg = !tg;
            q = {8'h00, ers ? 1'b0 : !pb7, tg, 6'h00};
        end else if (susp && sel[flash_addr[3:2]]) q = 16'h0080;
        else q = mem[flash_addr[3:0]];
    end
endmodule

/* File: verification/fcs_host_test.sv */
`include "fcs_map.vh"

module fcs_host_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
    logic        flash_reset_n_q, flash_byte_n_q, done_flag_pin, bm = 0;
    logic [20:0] flash_addr;
    logic [15:0] flash_dq_in, flash_dq_out;
    int          num_errors = 0, n_tests = 0;
    initial forever #2.5 pclk = ~pclk;
    fcs_host #(.WIN_CYC(200)) u_fcs_host (.*);
    fcs_flash_model u_fcs_flash_model (.*);
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        for (int i = 0; pready !== 1'b1; i++) begin
            if (i > 50) begin
                num_errors++;
                final_report();
            end
            @(posedge pclk);
        end
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // busy covers the bus cycles, the suspend wait and the reset pulse; device completion is found by polling
    task automatic op(input logic [3:0] o, input logic [20:0] a = 0, input logic [15:0] d = 0);
        apb(1, `FCS_REG_ADDR, {11'h0, a});
        apb(1, `FCS_REG_WDATA, {16'h0, d});
        apb(1, `FCS_REG_CTRL, {23'h0, bm, 4'h0, o});
        for (int i = 0; i < 9000; i++) begin
            apb(0, `FCS_REG_STAT, 0);
            if (r[0] === 1'b0) return;
        end
        num_errors++;
        final_report();
    endtask
    task automatic st(input logic [31:0] e);
        apb(0, `FCS_REG_STAT, 0);
        chk(r, e);
    endtask
    task automatic rd(input logic [20:0] a, input logic [15:0] e);
        op(`FCS_OP_READ, a);
        apb(0, `FCS_REG_RDATA, 0);
        chk(r, {16'h0, e});
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        st(32'h02);
        apb(0, 8'h20, 0);
        chk({r[30:0], err}, 32'h1);
        op(`FCS_OP_PROGRAM, 3, 16'h1234);
        st(32'h00);
        op(`FCS_OP_POLL, 3);
        rd(3, 16'h1234);
        op(`FCS_OP_PROGRAM, 3, 16'hFF00);
        op(`FCS_OP_POLL, 3);
        rd(3, 16'h1200);
        op(`FCS_OP_AUTOSEL);
        rd(2, 16'h0000);
        op(`FCS_OP_RESET);
        rd(3, 16'h1200);
        op(`FCS_OP_CHIP_ERASE);
        op(`FCS_OP_POLL, 3);
        rd(3, 16'hFFFF);
        op(`FCS_OP_PROGRAM, 8, 16'h0000);
        op(`FCS_OP_POLL, 8);
        op(`FCS_OP_SECT_ERASE, 8);
        st(32'h06);
        op(`FCS_OP_SUSPEND);
        rd(8, 16'h0080);
        rd(3, 16'hFFFF);
        op(`FCS_OP_RESUME);
        op(`FCS_OP_POLL, 8);
        rd(8, 16'hFFFF);
        bm = 1;
        op(`FCS_OP_PROGRAM, 4, 16'h5A5A);
        op(`FCS_OP_POLL, 4);
        rd(4, 16'h5A5A);
        bm = 0;
        op(`FCS_OP_CHIP_ERASE);
        op(`FCS_OP_HW_RESET);
        st(32'h02);
        op(4'hB);
        st(32'h12);
        final_report();
    end
endmodule
